// File: logic/enc_input_filter.sv
// synchroniser and selectable glitch filter for one encoder track
`include "enc_zm_defs.svh"
module enc_input_filter
  import enc_zm_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // track pin and filter setting
  input wire logic pin_raw,
  input wire logic [9:0] filt_cycles,
  // filtered level
  output logic filt_level
);
  filt_state_s q;
  filt_state_s n;

  // two-stage sync, then level must hold filt_cycles before it passes
  always_comb
  begin
    n = q;
    n.s1 = pin_raw;
    n.s2 = q.s1;
    if (filt_cycles == 10'h000)
    begin
      n.lvl = q.s2;
      n.cnt = 10'h000;
    end
    else if (q.s2 == q.lvl)
      n.cnt = 10'h000;
    else if (q.cnt + 10'h001 >= filt_cycles)
    begin
      n.lvl = q.s2;
      n.cnt = 10'h000;
    end
    else
      n.cnt = q.cnt + 10'h001;
  end

  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= '0;
    else
      q <= n;
  end

  assign filt_level = q.lvl;

  property p_bypass;
    @(posedge aclk) disable iff (!aresetn)
    (filt_cycles == 10'h000) |=> (q.lvl == $past(q.s2));
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("filter bypass does not follow input");
endmodule : enc_input_filter

// File: logic/enc_zm_correction.sv
// encoder zero-mark evaluation, pulse correction and band monitor
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`include "enc_zm_defs.svh"
module enc_zm_correction
  import enc_zm_pkg::*;
#(
  parameter int unsigned POLE_PAIRS = 4,
  parameter int unsigned ALARM_CYC =
    32'((`BAND_ALARM_S * 64'd1000000000) / `CLK_PERIOD_NS),
  parameter int unsigned FLAG_CYC =
    32'((`BAND_FLAG_MS * 64'd1000000) / `CLK_PERIOD_NS)
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // encoder pins
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_z,
  // commutation status from the controller
  input wire logic fine_sync_complete,
  // messages and results
  output logic zero_mark_distance_fault,
  output logic zero_mark_missing_fault,
  output logic correction_window_fault,
  output logic zero_mark_missing_alarm,
  output logic band_violation_alarm,
  output logic band_violation_flag,
  output logic [31:0] commutation_pole_position
);
  core_state_s q;
  core_state_s n;
  logic a_f;
  logic b_f;
  logic z_f;
  logic accept;
  logic band_hit;
  logic wr_corr;
  logic signed [31:0] refp;
  logic [31:0] rd;
  logic [31:0] wv;
  logic [1:0] ph_now;
  logic fwd;
  logic rev;
  logic filt_on;
  logic signed [31:0] e_cnt;
  logic signed [31:0] ival;
  logic signed [31:0] mag;
  logic signed [31:0] dev;
  logic signed [31:0] adev;
  logic signed [31:0] tgt;
  logic signed [31:0] run;
  logic signed [31:0] pole_s;
  logic signed [1:0] cstep;
  logic tick;

  // nearest supported filter step, in 10 ns units
  function automatic logic [11:0] nearest_step(input logic [13:0] r);
    if (r <= 14'h0002)
      return 12'h000;
    else if (r <= 14'h0022)
      return `FT_S1;
    else if (r <= 14'h00A0)
      return `FT_S2;
    else if (r <= 14'h0280)
      return `FT_S3;
    else if (r <= 14'h0600)
      return `FT_S4;
    else
      return `FT_S5;
  endfunction : nearest_step

  // byte-lane merge of a write into a register image
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction : merge

  // filter length in clock cycles follows the effective step
  logic [9:0] filt_cyc;
  assign filt_cyc = 10'((32'(q.eff_ft) * `FT_UNIT_NS) / `CLK_PERIOD_NS);

  // one filter per track
  enc_input_filter u_filt_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_raw(enc_a),
    .filt_cycles(filt_cyc),
    .filt_level(a_f)
  );
  enc_input_filter u_filt_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_raw(enc_b),
    .filt_cycles(filt_cyc),
    .filt_level(b_f)
  );
  enc_input_filter u_filt_z (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_raw(enc_z),
    .filt_cycles(filt_cyc),
    .filt_level(z_f)
  );

  // bus handshakes
  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready = !q.w_got && !q.bvalid;
  assign s_axi_arready = !q.rvalid;

  // whole next-state computation
  always_comb
  begin
    n = q;
    accept = 1'b0;
    band_hit = 1'b0;
    wr_corr = 1'b0;
    refp = q.pos;
    rd = 32'h0000_0000;
    wv = 32'h0000_0000;
    tick = 1'b0;
    cstep = 2'sd0;
    // filter active when nonzero
    filt_on = (q.eff_ft != 12'h000);
    e_cnt = $signed({14'h0000, q.ppr, 2'b00});
    // register writes; both channels may arrive in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
      n.bvalid = 1'b0;
    if (q.aw_got && q.w_got)
    begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RESP_OKAY;
      case (q.awaddr)
        `OFS_CTRL:
          n.ctrl = 6'(merge(32'(q.ctrl), q.wdata, q.wstrb));
        `OFS_FILT_REQ:
        begin
          // clamp request to 100 us
          wv = merge(32'(q.filt_req), q.wdata, q.wstrb);
          n.filt_req = (wv > 32'(`FILT_MAX_REQ)) ? `FILT_MAX_REQ : wv[13:0];
          // snap to nearest step
          n.eff_ft = nearest_step(n.filt_req);
        end
        `OFS_PPR:
          n.ppr = 16'(merge(32'(q.ppr), q.wdata, q.wstrb));
        `OFS_ZM_TOL:
          n.zm_tol = 16'(merge(32'(q.zm_tol), q.wdata, q.wstrb));
        `OFS_CORR_WIN:
          {n.cw_lo, n.cw_up} = merge({q.cw_lo, q.cw_up}, q.wdata, q.wstrb);
        `OFS_BAND:
          {n.bl_lo, n.bl_up} = merge({q.bl_lo, q.bl_up}, q.wdata, q.wstrb);
        `OFS_MIN_LEN:
          n.min_len = 16'(merge(32'(q.min_len), q.wdata, q.wstrb));
        `OFS_STATUS:
        begin
          // write one clears faults; hardware sets below win
          wv = merge(32'h0, q.wdata, q.wstrb);
          n.dist_f = q.dist_f && !wv[0];
          n.miss_f = q.miss_f && !wv[1];
          n.cw_f = q.cw_f && !wv[2];
        end
        `OFS_CORR_CNT:
        begin
          wr_corr = 1'b1;
          n.corr_acc = merge(q.corr_acc, q.wdata, q.wstrb);
        end
        `OFS_FILT_EFF, `OFS_POLE, `OFS_MEAS: ;
        default:
          n.bresp = `RESP_SLVERR;
      endcase
    end
    // register reads
    case (s_axi_araddr)
      `OFS_CTRL: rd = 32'(q.ctrl);
      `OFS_FILT_REQ: rd = 32'(q.filt_req);
      `OFS_FILT_EFF: rd = 32'(q.eff_ft);
      `OFS_PPR: rd = 32'(q.ppr);
      `OFS_ZM_TOL: rd = 32'(q.zm_tol);
      `OFS_CORR_WIN: rd = {q.cw_lo, q.cw_up};
      `OFS_BAND: rd = {q.bl_lo, q.bl_up};
      `OFS_MIN_LEN: rd = 32'(q.min_len);
      `OFS_STATUS:
        rd = {24'h000000, filt_on, q.dir_pos, band_violation_flag,
          band_violation_alarm, q.miss_a, q.cw_f, q.miss_f, q.dist_f};
      // display select
      `OFS_CORR_CNT:
        rd = q.ctrl[`CTRL_DISP_SEL] ? q.corr_acc : q.corr_int;
      `OFS_POLE: rd = q.pole;
      `OFS_MEAS: rd = q.meas;
      default: rd = 32'h0000_0000;
    endcase
    if (s_axi_rvalid && s_axi_rready)
      n.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      n.rvalid = 1'b1;
      n.rdata = rd;
      n.rresp = (rd == 32'h0 && !(s_axi_araddr <= `OFS_MEAS
        && s_axi_araddr[1:0] == 2'b00)) ? `RESP_SLVERR : `RESP_OKAY;
    end
    // quadrature decode into a signed edge count
    ph_now = {a_f, a_f ^ b_f};
    n.ph = ph_now;
    fwd = (2'(ph_now - q.ph) == 2'd1);
    rev = (2'(ph_now - q.ph) == 2'd3);
    if (fwd)
    begin
      n.pos = q.pos + 32'sd1;
      n.dir_pos = 1'b1;
    end
    else if (rev)
    begin
      n.pos = q.pos - 32'sd1;
      n.dir_pos = 1'b0;
    end
    // zero-mark detection
    case (q.zst)
      ZM_LOW:
        if (z_f)
        begin
          n.zst = ZM_HIGH;
          n.z_width = 16'h0000;
          n.snap = n.pos;
          // plain detection
          if (!q.ctrl[`CTRL_EDGE_EVAL])
          begin
            accept = 1'b1;
            refp = n.pos;
          end
        end
      ZM_HIGH:
      begin
        if ((fwd || rev) && q.z_width != 16'hFFFF)
          n.z_width = q.z_width + 16'h0001;
        if (!z_f)
        begin
          n.zst = ZM_LOW;
          // short marks dropped
          if (q.ctrl[`CTRL_EDGE_EVAL]
            && {2'b00, q.z_width} >= {q.min_len, 2'b00})
          begin
            accept = 1'b1;
            // rising edge forward
            refp = q.dir_pos ? q.snap : n.pos;
          end
        end
      end
      default: n.zst = ZM_LOW;
    endcase
    // interval figures
    ival = refp - q.ref_pos;
    mag = (ival < 0) ? -ival : ival;
    dev = mag - e_cnt;
    adev = (dev < 0) ? -dev : dev;
    tgt = ((ival >= 0) ? e_cnt : -e_cnt) - ival;
    run = n.pos - q.ref_pos;
    if (run < 0)
      run = -run;
    // controller-cycle tick
    if (32'(q.cc_cnt) >= `CC_CYC - 1)
    begin
      n.cc_cnt = 16'h0000;
      tick = 1'b1;
    end
    else
      n.cc_cnt = q.cc_cnt + 16'h0001;
    // quarter-pulse step after sync
    if (tick && q.pending != 16'sd0
      && (!q.ctrl[`CTRL_COMMUT_ZM] || fine_sync_complete))
    begin
      // one quarter pulse
      cstep = (q.pending > 0) ? 2'sd1 : -2'sd1;
      n.pending = q.pending - 16'(cstep);
      n.corr_acc = n.corr_acc + 32'(cstep);
      n.corr_int = q.corr_int + 32'(cstep);
    end
    // pole follows edges and correction
    pole_s = $signed(q.pole) + (fwd ? 32'sd1 : rev ? -32'sd1 : 32'sd0)
      + 32'(cstep);
    if (e_cnt == 0)
      pole_s = 32'sd0;
    else if (pole_s < 0)
      pole_s = pole_s + e_cnt;
    else if (pole_s >= e_cnt)
      pole_s = pole_s - e_cnt;
    n.pole = pole_s;
    if (accept)
    begin
      // restart interval
      n.ref_pos = refp;
      n.meas = ival;
      n.seen_zm = 1'b1;
      n.miss_a = 1'b0;
      n.corr_int = 32'sd0;
      if (q.seen_zm)
      begin
        // tolerance only without fixes
        if (!q.ctrl[`CTRL_CORR_EN] && !q.ctrl[`CTRL_ADAPT_EN]
          && q.ctrl[`CTRL_EQUIDIST] && !filt_on
          && adev > $signed({14'h0000, q.zm_tol, 2'b00}))
          n.dist_f = 1'b1;
        if (q.ctrl[`CTRL_CORR_EN])
        begin
          // outside correction window
          if (dev > $signed({14'h0000, q.cw_up, 2'b00})
            || -dev > $signed({14'h0000, q.cw_lo, 2'b00}))
          begin
            // filter hides fault
            if (!filt_on)
              n.cw_f = 1'b1;
          end
          else if (adev >= $signed({14'h0000, q.min_len, 2'b00}))
            n.pending = 16'(tgt);
        end
        // adaptation within band
        else if (q.ctrl[`CTRL_ADAPT_EN]
          && adev >= $signed({14'h0000, q.min_len, 2'b00}))
        begin
          // thirty degrees, quarter pulse
          if (64'(adev) * 64'(360 / `POLE_TOL_DEG) * 64'(POLE_PAIRS)
            <= 64'(e_cnt))
            n.pending = (tgt > 0) ? 16'sd1 : -16'sd1;
        end
        // band check per interval
        if (q.ctrl[`CTRL_CORR_EN] && q.bl_up != 16'h0000
          && q.bl_lo != 16'h0000
          && (mag > $signed({14'h0000, q.bl_up, 2'b00})
          || mag < $signed({14'h0000, q.bl_lo, 2'b00})))
          band_hit = 1'b1;
      end
    end
    // missing mark: alarm, then fault
    else if (e_cnt != 0 && run > e_cnt + (e_cnt >>> 1))
    begin
      if (q.miss_a && !filt_on)
        n.miss_f = 1'b1;
      n.miss_a = 1'b1;
      n.ref_pos = n.pos;
    end
    // alarm and flag timers
    if (band_hit)
    begin
      n.alarm_cnt = 28'(ALARM_CYC);
      n.flag_cnt = 22'(FLAG_CYC);
    end
    else
    begin
      if (q.alarm_cnt != 28'h0)
        n.alarm_cnt = q.alarm_cnt - 28'h1;
      if (q.flag_cnt != 22'h0)
        n.flag_cnt = q.flag_cnt - 22'h1;
    end
  end

  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.ctrl <= `RST_CTRL;
      q.ppr <= `RST_PPR;
      q.min_len <= `RST_MIN_LEN;
    end
    else
      q <= n;
  end

  // outputs
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign zero_mark_distance_fault = q.dist_f;
  assign zero_mark_missing_fault = q.miss_f;
  assign correction_window_fault = q.cw_f;
  assign zero_mark_missing_alarm = q.miss_a;
  // flag with alarm
  assign band_violation_alarm = (q.alarm_cnt != 28'h0);
  assign band_violation_flag = (q.flag_cnt != 22'h0);
  assign commutation_pole_position = q.pole;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_violation;
    band_hit;
  endsequence
  sequence s_raised;
    band_violation_alarm && band_violation_flag;
  endsequence

  property p_filt_range;
    q.filt_req <= `FILT_MAX_REQ;
  endproperty
  a_filt_range: assert property (p_filt_range)
    else $error("filter request above limit");
  property p_eff_match;
    q.eff_ft == nearest_step(q.filt_req);
  endproperty
  a_eff_match: assert property (p_eff_match)
    else $error("effective filter not nearest step");
  property p_filt_quiet;
    ($rose(q.dist_f) || $rose(q.cw_f) || $rose(q.miss_f))
      |-> $past(q.eff_ft) == 12'h000;
  endproperty
  a_filt_quiet: assert property (p_filt_quiet)
    else $error("fault raised with filter active");
  property p_band_raise;
    s_violation |=> s_raised;
  endproperty
  a_band_raise: assert property (p_band_raise)
    else $error("band alarm or flag missing");
  property p_band_off;
    (q.bl_up == 16'h0000 || q.bl_lo == 16'h0000) |-> !band_hit;
  endproperty
  a_band_off: assert property (p_band_off)
    else $error("band alarm with zero limit");
  property p_flag_hold;
    $rose(band_violation_flag) |=> band_violation_flag [*8];
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("band flag dropped early");
  property p_sync_wait;
    (q.ctrl[`CTRL_COMMUT_ZM] && !fine_sync_complete && !wr_corr)
      |=> $stable(q.corr_acc);
  endproperty
  a_sync_wait: assert property (p_sync_wait)
    else $error("correction before fine sync");
  property p_corr_rate;
    ($changed(q.corr_acc) && !$past(wr_corr))
      |-> (q.corr_acc - $past(q.corr_acc) == 32'sd1
      || $past(q.corr_acc) - q.corr_acc == 32'sd1);
  endproperty
  a_corr_rate: assert property (p_corr_rate)
    else $error("correction step not one quarter pulse");
  property p_restart;
    accept |=> q.ref_pos == $past(refp) && q.corr_int == 32'sd0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("interval not restarted at zero mark");
endmodule : enc_zm_correction

// File: logic/enc_zm_defs.svh
// constants for the zero-mark pulse correction block
// Function
// - filter on when filter time nonzero; requests 0..100 us
// - filter steps 0, 0.04, 0.64, 2.56, 10.24, 20.48 us only
// - odd request goes to nearest step silently; step is readable
// - active filter suppresses distance, missing and window faults
// - edge mode: rising edge forward, falling edge reverse
// - edge enable clear keeps plain detection; set selects edges
// - without adapt or correction, deviations within tolerance pass
// - adaptation adds missing and removes surplus pulses at mark
// - adaptation band +-30 el. degrees, one quarter pulse per mark
// - zero-mark commutation waits for fine sync before correcting
// - correction fixes errors inside window, quarter pulse per cycle
// - deviation beyond correction window raises window fault
// - correction also moves pole position, never the speed
// - minimum length defaults 1; gates small fixes and short marks
// - absent zero mark gives missing alarm then missing fault
// - after each mark, check count against band limits
// - band violation with correction on raises alarm for 5 s
// - either band limit zero disables the band alarm
// - display bit picks accumulated or per-interval corrections
// - band flag set with alarm and held at least 100 ms
// - each mark restarts band measurement; in-band drift is quiet
`ifndef ENC_ZM_DEFS_SVH
`define ENC_ZM_DEFS_SVH
`define OFS_CTRL 8'h00
`define OFS_FILT_REQ 8'h04
`define OFS_FILT_EFF 8'h08
`define OFS_PPR 8'h0C
`define OFS_ZM_TOL 8'h10
`define OFS_CORR_WIN 8'h14
`define OFS_BAND 8'h18
`define OFS_MIN_LEN 8'h1C
`define OFS_STATUS 8'h20
`define OFS_CORR_CNT 8'h24
`define OFS_POLE 8'h28
`define OFS_MEAS 8'h2C
`define CTRL_EDGE_EVAL 0
`define CTRL_CORR_EN 1
`define CTRL_ADAPT_EN 2
`define CTRL_COMMUT_ZM 3
`define CTRL_DISP_SEL 4
`define CTRL_EQUIDIST 5
`define RST_CTRL 6'h00
`define RST_PPR 16'h0800
`define RST_MIN_LEN 16'h0001
`define CLK_PERIOD_NS 40
`define FT_UNIT_NS 10
`define FILT_MAX_REQ 14'h2710
`define FT_S1 12'h004
`define FT_S2 12'h040
`define FT_S3 12'h100
`define FT_S4 12'h400
`define FT_S5 12'h800
`define CC_PERIOD_NS 125000
`define CC_CYC (`CC_PERIOD_NS / `CLK_PERIOD_NS)
`define BAND_ALARM_S 5
`define BAND_FLAG_MS 100
`define POLE_TOL_DEG 30
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: logic/enc_zm_pkg.sv
// types shared by the zero-mark correction block
package enc_zm_pkg;
  typedef enum logic {ZM_LOW, ZM_HIGH} zm_state_e;
  typedef struct packed {
    logic s1;
    logic s2;
    logic lvl;
    logic [9:0] cnt;
  } filt_state_s;
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [5:0] ctrl;
    logic [13:0] filt_req;
    logic [11:0] eff_ft;
    logic [15:0] ppr;
    logic [15:0] zm_tol;
    logic [15:0] cw_up;
    logic [15:0] cw_lo;
    logic [15:0] bl_up;
    logic [15:0] bl_lo;
    logic [15:0] min_len;
    logic [1:0] ph;
    logic dir_pos;
    zm_state_e zst;
    logic [15:0] z_width;
    logic signed [31:0] pos;
    logic signed [31:0] snap;
    logic signed [31:0] ref_pos;
    logic signed [31:0] meas;
    logic seen_zm;
    logic signed [15:0] pending;
    logic [31:0] pole;
    logic signed [31:0] corr_acc;
    logic signed [31:0] corr_int;
    logic [15:0] cc_cnt;
    logic dist_f;
    logic miss_f;
    logic cw_f;
    logic miss_a;
    logic [27:0] alarm_cnt;
    logic [21:0] flag_cnt;
  } core_state_s;
endpackage : enc_zm_pkg

// File: sim/encoder_zero_mark_pulse_correction_tb.sv
// bench for the zero-mark pulse correction block
`include "enc_zm_defs.svh"
`define CHK(g, e) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("[FAIL] %0t got %h exp %h", $time, g, e); \
    end \
  end
module encoder_zero_mark_pulse_correction_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, fine_sync_complete;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, commutation_pole_position, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, enc_a, enc_b, enc_z;
  logic zero_mark_distance_fault, zero_mark_missing_fault;
  logic correction_window_fault, zero_mark_missing_alarm;
  logic band_violation_alarm, band_violation_flag;
  int fail_count, n_tests;
  logic [31:0] fq [8] = '{32'h0, 32'h4, 32'h1E, 32'h22, 32'hC8, 32'h3E8,
    32'h640, 32'h2710};
  logic [31:0] fe [8] = '{32'h0, 32'h4, 32'h4, 32'h4, 32'h100, 32'h400,
    32'h800, 32'h800};
  // block under test with short alarm and flag spans
  enc_zm_correction #(.ALARM_CYC(200), .FLAG_CYC(50)) dut_u (.aclk,
    .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .enc_a, .enc_b,
    .enc_z, .fine_sync_complete, .zero_mark_distance_fault,
    .zero_mark_missing_fault, .correction_window_fault,
    .zero_mark_missing_alarm, .band_violation_alarm, .band_violation_flag,
    .commutation_pole_position);
  quad_encoder_model enc_u (.aclk(aclk), .enc_a(enc_a), .enc_b(enc_b),
    .enc_z(enc_z));
  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // one write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int t;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    t = 0;
    do
    begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      t++;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    while (!tb && t < 50);
    s_axi_bready <= 1'b0;
    if (!tb) fail_count++;
  endtask : wr
  // one read, result left in rd and rs
  task automatic rdr(input logic [7:0] a);
    logic ta, tr;
    int t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    t = 0;
    do
    begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      t++;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    while (!tr && t < 50);
    s_axi_rready <= 1'b0;
    if (!tr) fail_count++;
  endtask : rdr
  // clock
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // watchdog
  initial
  begin
    repeat (30000) @(posedge aclk);
    fail_count++;
    tally_and_finish();
  end
  // main sequence
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    fine_sync_complete = 1'b1;
    fail_count = 0;
    n_tests = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(`OFS_MIN_LEN);
    `CHK(rd, 32'h1);
    rdr(8'h30);
    `CHK(rs, `RESP_SLVERR);
    for (int i = 0; i < 8; i++)
    begin
      wr(`OFS_FILT_REQ, fq[i]);
      rdr(`OFS_FILT_EFF);
      `CHK(rd, fe[i]);
    end
    rdr(`OFS_STATUS);
    `CHK(rd[7], 1'b1);
    wr(`OFS_FILT_REQ, 32'h0);
    wr(`OFS_PPR, 32'h8);
    wr(`OFS_BAND, 32'h0007_0009);
    wr(`OFS_CORR_WIN, 32'h0004_0004);
    wr(`OFS_MIN_LEN, 32'h1);
    wr(`OFS_CTRL, 32'h2);
    enc_u.mark();
    enc_u.move(32, 1'b1);
    enc_u.mark();
    rdr(`OFS_MEAS);
    if (rd[31]) rd = -rd;
    `CHK(rd, 32'h20);
    `CHK(band_violation_alarm, 1'b0);
    enc_u.move(40, 1'b1);
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    `CHK(commutation_pole_position, 32'h8);
    enc_u.mark();
    `CHK(band_violation_alarm, 1'b1);
    `CHK(band_violation_flag, 1'b1);
    `CHK(correction_window_fault, 1'b0);
    repeat (40) @(posedge aclk);
    `CHK(band_violation_flag, 1'b1);
    repeat (120) @(posedge aclk);
    `CHK(band_violation_alarm, 1'b1);
    repeat (60) @(posedge aclk);
    `CHK(band_violation_alarm, 1'b0);
    wr(`OFS_BAND, 32'h0000_0009);
    enc_u.move(40, 1'b1);
    enc_u.mark();
    `CHK(band_violation_alarm, 1'b0);
    wr(`OFS_CORR_WIN, 32'h0001_0001);
    enc_u.move(40, 1'b1);
    enc_u.mark();
    `CHK(correction_window_fault, 1'b1);
    enc_u.move(60, 1'b1);
    `CHK(zero_mark_missing_alarm, 1'b1);
    wr(`OFS_STATUS, 32'h7);
    wr(`OFS_FILT_REQ, 32'h4);
    enc_u.mark();
    enc_u.move(40, 1'b1);
    enc_u.mark();
    `CHK(correction_window_fault, 1'b0);
    tally_and_finish();
  end
endmodule : encoder_zero_mark_pulse_correction_tb

// File: sim/quad_encoder_model.sv
// behavioural quadrature encoder with zero mark
module quad_encoder_model (
  // clock
  input wire logic aclk,
  // encoder tracks
  output logic enc_a,
  output logic enc_b,
  output logic enc_z
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph;
  initial
  begin
    ph = 2'h0;
    enc_a = 1'b0;
    enc_b = 1'b0;
    enc_z = 1'b0;
  end
  // gray sequence, one track edge every four clocks
  task automatic move(input int n, input logic fwd);
    repeat (n)
    begin
      repeat (4) @(posedge aclk);
      ph = fwd ? ph + 2'h1 : ph - 2'h1;
      enc_a <= ph[1];
      enc_b <= ph[1] ^ ph[0];
    end
  endtask : move
  // zero mark pulse while the shaft stands
  task automatic mark();
    @(posedge aclk);
    enc_z <= 1'b1;
    repeat (3) @(posedge aclk);
    enc_z <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask : mark
endmodule : quad_encoder_model
